// ===== pkg/eprom_host_pkg.sv
package eprom_host_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam int CLK_PERIOD_NS = 25;
  localparam int ACCESS_NS = 250;
  localparam int GATE_DELAY_NS = 100;
  localparam int PULSE_US = 100;
  localparam int SUPPLY_SETTLE_US = 2;
  localparam int SIG_ENTRY_BIT = 9;
  localparam int SIG_BYTE_BIT = 0;
  // Least times round up to whole cycles
  localparam int ACCESS_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int GATE_CYC = (GATE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PULSE_CYC = (PULSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SUPPLY_SETTLE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    OP_READ,
    OP_PROGRAM,
    OP_VERIFY,
    OP_SIGNATURE
  } op_t;

  typedef struct packed {
    op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic sig_part;
  } req_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic mismatch;
  } resp_t;

  typedef struct packed {
    logic select_n;
    logic gate_n;
    logic supply_high;
    logic signature_entry_line;
    logic [ADDR_W-1:0] addr;
  } pins_t;
endpackage

// ===== test/eprom_host_checker.sv
`timescale 1ns/10ps
module eprom_host_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Device side
  input wire eprom_host_pkg::pins_t pins,
  input wire logic data_oe
);
  import eprom_host_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_PGM_MODE: assert property (data_oe |-> pins.supply_high && !pins.select_n)
    else $error("data driven outside program mode");
  AST_PGM_DRIVE: assert property (pins.supply_high && !pins.select_n |-> pins.gate_n && data_oe)
    else $error("program pulse without byte on the data pins");
  AST_VERIFY: assert property (pins.supply_high && !pins.gate_n |-> pins.select_n && !data_oe)
    else $error("verify levels wrong");
  AST_READ_SEL: assert property (!pins.gate_n && !pins.supply_high |-> !pins.select_n)
    else $error("gate low without select");
  AST_SIG_ADDR: assert property (pins.signature_entry_line |-> (pins.addr & 15'h7DFE) == 15'h0000)
    else $error("signature address lines not low");
  AST_SIG_SUPPLY: assert property (pins.signature_entry_line |-> !pins.supply_high)
    else $error("signature with supply raised");
endmodule
bind eprom_host eprom_host_checker eprom_host_checker_inst (.clk(clk), .rst(rst), .pins(pins),
  .data_oe(data_oe));

// ===== test/eprom_model.sv
`timescale 1ns/10ps
module eprom_model #(
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary value
) (
  // Controller side
  input wire logic clk,
  input wire eprom_host_pkg::pins_t pins,
  input wire logic [7:0] data_out,
  output logic [7:0] data_in
);
  import eprom_host_pkg::*;
  logic [7:0] mem [32768];
  logic [7:0] val;
  logic [7:0] last;
  logic drv;
  int gate_age = 0;
  // Starts high so a first read of an erased cell cannot pass on a floating bus
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    last = 8'hFF;
  end
  assign drv = !pins.gate_n && (!pins.select_n || pins.supply_high);
  assign val = !pins.signature_entry_line ? mem[pins.addr] :
    (pins.addr[0] ? PART_ID : MAKER_ID);
  // Released bus, or data not yet through the gate delay, shows the inverse
  assign data_in = (drv && gate_age >= GATE_CYC) ? val : ~last;
  always @(posedge clk) begin
    gate_age <= drv ? gate_age + 1 : 0;
    if (drv && gate_age >= GATE_CYC) last <= val;
  end
  // Cells only clear; a select held high never writes
  always @(posedge pins.select_n) if (pins.supply_high && pins.gate_n)
    mem[pins.addr] <= mem[pins.addr] & data_out;
endmodule

// ===== test/uv_eprom_mode_control_bench.sv
`timescale 1ns/10ps
module uv_eprom_mode_control_bench;
  import eprom_host_pkg::*;
  logic clk = 0, rst = 1, req_valid = 0, req_ready, resp_valid, data_oe;
  req_t req = '0;
  resp_t resp;
  pins_t pins;
  logic [7:0] data_in, data_out;
  int fails = 0, check_count = 0;
  eprom_host #(.PULSE_CYCLES(8), .SETTLE_CYCLES(4)) eprom_host_inst (.clk(clk), .rst(rst),
    .req_valid(req_valid), .req(req), .req_ready(req_ready), .resp_valid(resp_valid),
    .resp(resp), .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  eprom_model eprom_model_inst (.clk(clk), .pins(pins), .data_out(data_out), .data_in(data_in));
  task automatic chk(input string what, input logic [7:0] seen, exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic run(input op_t o, input logic [14:0] a, input logic [7:0] d, input logic p);
    int n;
    n = 0;
    req = '{o, a, d, p};
    req_valid = 1;
    @(posedge clk);
    #2 req_valid = 0;
    chk("busy", {7'h00, req_ready}, 8'h00);
    do begin
      @(posedge clk);
      #2 n++;
    end while (resp_valid !== 1'b1 && n < 99);
    if (n >= 99) fails++;
    chk("ready", {7'h00, req_ready}, 8'h01);
  endtask
  task automatic t_erase;
    run(OP_READ, 15'h7FFF, 8'h00, 1'b0);
    chk("erased", resp.data, 8'hFF);
    $display("erase test done");
  endtask
  task automatic t_prog;
    run(OP_PROGRAM, 15'h0123, 8'hA5, 1'b0);
    run(OP_PROGRAM, 15'h0123, 8'h0F, 1'b0);
    run(OP_READ, 15'h0123, 8'h00, 1'b0);
    chk("program", resp.data, 8'h05);
    run(OP_VERIFY, 15'h0123, 8'h05, 1'b0);
    chk("verify ok", {7'h00, resp.mismatch}, 8'h00);
    run(OP_VERIFY, 15'h0123, 8'h00, 1'b0);
    chk("verify bad", {7'h00, resp.mismatch}, 8'h01);
    run(OP_READ, 15'h0123, 8'h00, 1'b0);
    chk("inhibit", resp.data, 8'h05);
    run(OP_READ, 15'h0124, 8'h00, 1'b0);
    chk("neighbour", resp.data, 8'hFF);
    $display("program test done");
  endtask
  task automatic t_sig;
    run(OP_SIGNATURE, 15'h0000, 8'h00, 1'b0);
    chk("maker", resp.data, 8'h3C);
    run(OP_SIGNATURE, 15'h0000, 8'h00, 1'b1);
    chk("part", resp.data, 8'hA5);
    $display("signature test done");
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial forever #12.5 clk = ~clk;
  initial begin
    repeat (3) @(posedge clk);
    #2 rst = 0;
    t_erase;
    t_prog;
    t_sig;
    summarize;
  end
  // About ten operations of some twenty cycles each fit well inside this
  initial begin
    #100000;
    fails++;
    summarize;
  end
endmodule

// ===== verilog/eprom_host.sv
`timescale 1ns/10ps
module eprom_host #(
  parameter int PULSE_CYCLES = eprom_host_pkg::PULSE_CYC,
  parameter int SETTLE_CYCLES = eprom_host_pkg::SETTLE_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // User request and answer
  input wire logic req_valid,
  input wire eprom_host_pkg::req_t req,
  output logic req_ready,
  output logic resp_valid,
  output eprom_host_pkg::resp_t resp,
  // Device pins
  output eprom_host_pkg::pins_t pins,
  input wire logic [eprom_host_pkg::DATA_W-1:0] data_in,
  output logic [eprom_host_pkg::DATA_W-1:0] data_out,
  output logic data_oe
);
  import eprom_host_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE,
    S_SETTLE,
    S_ACCESS,
    S_PULSE,
    S_RECOVER,
    S_DONE
  } state_t;

  localparam int CNT_W = 24;

  state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  req_t cur_q;

  function automatic logic [CNT_W-1:0] cyc(input int n);
    cyc = CNT_W'(n - 1);
  endfunction

  // Address presented to the device; signature clears all other lines
  function automatic logic [ADDR_W-1:0] sig_addr(input logic part);
    logic [ADDR_W-1:0] a;
    a = '0;
    a[SIG_BYTE_BIT] = part;
    sig_addr = a;
  endfunction

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= S_IDLE;
      cnt_q <= '0;
      cur_q <= '0;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (req_valid) begin
            cur_q <= req;
            if (req.op == OP_PROGRAM || req.op == OP_VERIFY) begin
              state_q <= S_SETTLE;
              cnt_q <= cyc(SETTLE_CYCLES);
            end else begin
              state_q <= S_ACCESS;
              cnt_q <= cyc(ACCESS_CYC);
            end
          end
        end
        S_SETTLE: begin
          if (cnt_q == '0) begin
            if (cur_q.op == OP_PROGRAM) begin
              state_q <= S_PULSE;
              cnt_q <= cyc(PULSE_CYCLES);
            end else begin
              state_q <= S_ACCESS;
              cnt_q <= cyc(ACCESS_CYC);
            end
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_ACCESS: begin
          if (cnt_q == '0) begin
            state_q <= S_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_PULSE: begin
          if (cnt_q == '0) begin
            state_q <= S_RECOVER;
            cnt_q <= cyc(GATE_CYC);
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        S_RECOVER: begin
          if (cnt_q == '0) begin
            state_q <= S_DONE;
          end else begin
            cnt_q <= cnt_q - 1'b1;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // Pin drive, registered so the pins never glitch
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins <= '{select_n: 1'b1, gate_n: 1'b1, supply_high: 1'b0,
                signature_entry_line: 1'b0, addr: '0};
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      pins.select_n <= 1'b1;
      pins.gate_n <= 1'b1;
      data_oe <= 1'b0;
      case (state_q)
        S_SETTLE, S_PULSE, S_RECOVER: begin
          pins.supply_high <= 1'b1;
          if (state_q == S_PULSE && cnt_q != '0) begin
            pins.select_n <= 1'b0;
            data_oe <= 1'b1;
          end else if (cur_q.op == OP_VERIFY) begin
            pins.gate_n <= 1'b0;
          end
          data_out <= cur_q.data;
        end
        S_ACCESS: begin
          pins.supply_high <= (cur_q.op == OP_VERIFY);
          if (cur_q.op != OP_VERIFY) begin
            pins.select_n <= 1'b0;
          end
          pins.gate_n <= 1'b0;
        end
        S_IDLE: begin
          if (req_valid) begin
            pins.signature_entry_line <= (req.op == OP_SIGNATURE);
            pins.addr <= (req.op == OP_SIGNATURE) ? sig_addr(req.sig_part) : req.addr;
          end
          pins.supply_high <= 1'b0;
        end
        default: begin
          pins.supply_high <= 1'b0;
          pins.signature_entry_line <= 1'b0;
        end
      endcase
    end
  end

  // Handshake and answer; data sampled after the full access delay
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_ready <= 1'b1;
      resp_valid <= 1'b0;
      resp <= '0;
    end else begin
      resp_valid <= 1'b0;
      if (state_q == S_IDLE && req_valid) begin
        req_ready <= 1'b0;
      end
      if (state_q == S_ACCESS && cnt_q == '0) begin
        resp.data <= data_in;
        // Verify passes when read byte equals the requested one
        resp.mismatch <= (cur_q.op == OP_VERIFY) && (data_in != cur_q.data);
      end
      if (state_q == S_DONE) begin
        resp_valid <= 1'b1;
        req_ready <= 1'b1;
        if (cur_q.op == OP_PROGRAM) begin
          resp <= '0;
        end
      end
    end
  end
endmodule
